/* File: design/lmmd_pkg.sv */
// shared types and opcode constants for the load/move/multiply decoder
package lmmd_pkg;

  // ==========================================
  // instruction field layout (bit 0 of the word is the lsb, the final bit)
  localparam int LMMD_INSTR_W = 32;
  localparam int PRI_HI = 31;
  localparam int PRI_LO = 26;
  localparam int XO_HI = 10;
  localparam int XO_LO = 1;
  localparam int RC_BIT = 0;
  localparam int LMMD_NUM_PAT = 34;

  // ==========================================
  // primary opcodes
  localparam logic [5:0] PRI_EXT = 6'h1f;
  localparam logic [5:0] PRI_FLAG_OPS = 6'h13;
  localparam logic [5:0] PRI_FLOAT = 6'h3f;
  localparam logic [5:0] PRI_LD_WORD = 6'h20;
  localparam logic [5:0] PRI_LD_WORD_U = 6'h21;
  localparam logic [5:0] PRI_MUL_IMM = 6'h07;

  // ==========================================
  // extended opcodes, ten bits above the final bit
  localparam logic [9:0] XO_LD_HALF_X = 10'h117;
  localparam logic [9:0] XO_LD_STR_IMM = 10'h255;
  localparam logic [9:0] XO_LD_STR_X = 10'h215;
  localparam logic [9:0] XO_LD_RESV_X = 10'h014;
  localparam logic [9:0] XO_LD_REV_X = 10'h216;
  localparam logic [9:0] XO_LD_WORD_UX = 10'h037;
  localparam logic [9:0] XO_LD_WORD_X = 10'h017;
  localparam logic [9:0] XO_FLAGS_COPY = 10'h000;
  localparam logic [9:0] XO_FLAGS_FROM_FLOAT = 10'h040;
  localparam logic [9:0] XO_FLAGS_FROM_FXE = 10'h200;
  localparam logic [9:0] XO_FLAGS_TO_GPR = 10'h013;
  localparam logic [9:0] XO_DEV_READ = 10'h143;
  localparam logic [9:0] XO_DEV_READ_X = 10'h103;
  localparam logic [9:0] XO_FLOAT_READ = 10'h247;
  localparam logic [9:0] XO_STATE_READ = 10'h053;
  localparam logic [9:0] XO_SPR_READ = 10'h153;
  localparam logic [9:0] XO_FLAGS_WRITE = 10'h090;
  localparam logic [9:0] XO_DEV_WRITE = 10'h1c3;
  localparam logic [9:0] XO_DEV_WRITE_X = 10'h183;
  localparam logic [9:0] XO_FLOAT_BIT_CLR = 10'h046;
  localparam logic [9:0] XO_FLOAT_BIT_SET = 10'h026;
  localparam logic [9:0] XO_FLOAT_WRITE = 10'h2c7;
  localparam logic [9:0] XO_FLOAT_WRITE_IMM = 10'h086;
  localparam logic [9:0] XO_STATE_WRITE = 10'h092;
  localparam logic [9:0] XO_SPR_WRITE = 10'h1d3;
  localparam logic [9:0] XO_MUL_HIGH = 10'h04b;
  localparam logic [9:0] XO_MUL_HIGH_U = 10'h00b;
  localparam logic [9:0] XO_MUL_LOW = 10'h0eb;
  localparam logic [9:0] XO_MUL_LOW_SUM = 10'h2eb;
  localparam logic [9:0] XO_NEGATE = 10'h068;
  localparam logic [9:0] XO_NEGATE_SUM = 10'h268;
  localparam logic [9:0] XO_NONE = 10'h000;

  // ==========================================
  // compare and reserved masks over the extended field
  localparam logic [9:0] XM_ALL = 10'h3ff;
  localparam logic [9:0] XM_NONE = 10'h000;
  localparam logic [9:0] XM_LOW9 = 10'h1ff;
  localparam logic [9:0] XM_TOP = 10'h200;

  // ==========================================
  // types
  typedef enum logic [1:0] {RC_FREE, RC_RSVD, RC_REC} lmmd_rc_t;

  typedef enum logic [5:0] {
    OP_NONE, OP_LD_HALF_X, OP_LD_STR_IMM, OP_LD_STR_X, OP_LD_RESV_X,
    OP_LD_REV_X, OP_LD_WORD, OP_LD_WORD_U, OP_LD_WORD_UX, OP_LD_WORD_X,
    OP_FLAGS_COPY, OP_FLAGS_FROM_FLOAT, OP_FLAGS_FROM_FXE, OP_FLAGS_TO_GPR,
    OP_DEV_READ, OP_DEV_READ_X, OP_FLOAT_READ, OP_STATE_READ, OP_SPR_READ,
    OP_FLAGS_WRITE, OP_DEV_WRITE, OP_DEV_WRITE_X, OP_FLOAT_BIT_CLR,
    OP_FLOAT_BIT_SET, OP_FLOAT_WRITE, OP_FLOAT_WRITE_IMM, OP_STATE_WRITE,
    OP_SPR_WRITE, OP_MUL_HIGH, OP_MUL_HIGH_U, OP_MUL_LOW_IMM, OP_MUL_LOW,
    OP_MUL_LOW_SUM, OP_NEGATE, OP_NEGATE_SUM
  } lmmd_op_t;

  typedef struct packed {
    logic [5:0] primary;
    logic [9:0] xo;
    logic rc;
  } lmmd_fields_t;

  typedef struct packed {
    lmmd_op_t op;
    logic rec_flags;
    logic invalid_form;
    logic illegal;
  } lmmd_dec_t;

  typedef struct packed {
    logic [5:0] primary;
    logic [9:0] xo;
    logic [9:0] xo_mask;
    logic [9:0] res_mask;
    lmmd_rc_t rc_mode;
    lmmd_op_t op;
  } lmmd_pat_t;

  localparam lmmd_dec_t DEC_IDLE = '{OP_NONE, 1'b0, 1'b0, 1'b0};

endpackage

/* File: design/lmmd_field_split.sv */
// splits a fetched word into primary, extended and final-bit fields
`timescale 1ns/1ps
module lmmd_field_split (
  input wire logic [lmmd_pkg::LMMD_INSTR_W-1:0] instr_i,
  output lmmd_pkg::lmmd_fields_t fields_o
);
  import lmmd_pkg::*;

  // ==========================================
  // field extraction
  // lsb-zero numbering, primary in the top six bits
  assign fields_o.primary = instr_i[PRI_HI:PRI_LO];
  assign fields_o.xo = instr_i[XO_HI:XO_LO];
  assign fields_o.rc = instr_i[RC_BIT];

endmodule

/* File: design/lmmd_out_stage.sv */
// output register stage holding the decoded selects
`timescale 1ns/1ps
module lmmd_out_stage (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic next_valid_i,
  input lmmd_pkg::lmmd_dec_t next_dec_i,
  output logic valid_o,
  output lmmd_pkg::lmmd_dec_t dec_o
);
  import lmmd_pkg::*;

  // ==========================================
  // register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
      dec_o <= DEC_IDLE;
    end else begin
      valid_o <= next_valid_i;
      dec_o <= next_dec_i;
    end
  end

endmodule

/* File: design/lmmd_decoder.sv */
// opcode decoder for loads, flag and status moves, multiplies and negate
`timescale 1ns/1ps
module lmmd_decoder #(
  parameter int NUM_PAT = lmmd_pkg::LMMD_NUM_PAT
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic fetch_valid_i,
  input wire logic [lmmd_pkg::LMMD_INSTR_W-1:0] fetch_instr_i,
  output logic dec_valid_o,
  output lmmd_pkg::lmmd_dec_t dec_o
);
  import lmmd_pkg::*;

  // ==========================================
  // elaboration check
  if (NUM_PAT != LMMD_NUM_PAT) begin : g_bad_num
    $error("pattern count must match the decode table");
  end

  // ==========================================
  // decode table: opcode, compare mask, reserved mask, final bit, select
  localparam lmmd_pat_t PAT [LMMD_NUM_PAT] = '{
    '{PRI_EXT, XO_LD_HALF_X, XM_ALL, XM_NONE, RC_RSVD, OP_LD_HALF_X},
    '{PRI_EXT, XO_LD_STR_IMM, XM_ALL, XM_NONE, RC_RSVD, OP_LD_STR_IMM},
    '{PRI_EXT, XO_LD_STR_X, XM_ALL, XM_NONE, RC_RSVD, OP_LD_STR_X},
    '{PRI_EXT, XO_LD_RESV_X, XM_ALL, XM_NONE, RC_RSVD, OP_LD_RESV_X},
    '{PRI_EXT, XO_LD_REV_X, XM_ALL, XM_NONE, RC_RSVD, OP_LD_REV_X},
    // word loads, immediate forms ignore the low field
    '{PRI_LD_WORD, XO_NONE, XM_NONE, XM_NONE, RC_FREE, OP_LD_WORD},
    '{PRI_LD_WORD_U, XO_NONE, XM_NONE, XM_NONE, RC_FREE, OP_LD_WORD_U},
    '{PRI_EXT, XO_LD_WORD_UX, XM_ALL, XM_NONE, RC_RSVD, OP_LD_WORD_UX},
    '{PRI_EXT, XO_LD_WORD_X, XM_ALL, XM_NONE, RC_RSVD, OP_LD_WORD_X},
    '{PRI_FLAG_OPS, XO_FLAGS_COPY, XM_ALL, XM_NONE, RC_RSVD, OP_FLAGS_COPY},
    '{PRI_FLOAT, XO_FLAGS_FROM_FLOAT, XM_ALL, XM_NONE, RC_RSVD,
      OP_FLAGS_FROM_FLOAT},
    '{PRI_EXT, XO_FLAGS_FROM_FXE, XM_ALL, XM_NONE, RC_RSVD,
      OP_FLAGS_FROM_FXE},
    '{PRI_EXT, XO_FLAGS_TO_GPR, XM_ALL, XM_NONE, RC_RSVD, OP_FLAGS_TO_GPR},
    '{PRI_EXT, XO_DEV_READ, XM_ALL, XM_NONE, RC_RSVD, OP_DEV_READ},
    '{PRI_EXT, XO_DEV_READ_X, XM_ALL, XM_NONE, RC_RSVD, OP_DEV_READ_X},
    '{PRI_FLOAT, XO_FLOAT_READ, XM_ALL, XM_NONE, RC_REC, OP_FLOAT_READ},
    '{PRI_EXT, XO_STATE_READ, XM_ALL, XM_NONE, RC_RSVD, OP_STATE_READ},
    '{PRI_EXT, XO_SPR_READ, XM_ALL, XM_NONE, RC_RSVD, OP_SPR_READ},
    '{PRI_EXT, XO_FLAGS_WRITE, XM_ALL, XM_NONE, RC_RSVD, OP_FLAGS_WRITE},
    '{PRI_EXT, XO_DEV_WRITE, XM_ALL, XM_NONE, RC_RSVD, OP_DEV_WRITE},
    '{PRI_EXT, XO_DEV_WRITE_X, XM_ALL, XM_NONE, RC_RSVD, OP_DEV_WRITE_X},
    '{PRI_FLOAT, XO_FLOAT_BIT_CLR, XM_ALL, XM_NONE, RC_REC,
      OP_FLOAT_BIT_CLR},
    '{PRI_FLOAT, XO_FLOAT_BIT_SET, XM_ALL, XM_NONE, RC_REC,
      OP_FLOAT_BIT_SET},
    '{PRI_FLOAT, XO_FLOAT_WRITE, XM_ALL, XM_NONE, RC_REC, OP_FLOAT_WRITE},
    '{PRI_FLOAT, XO_FLOAT_WRITE_IMM, XM_ALL, XM_NONE, RC_REC,
      OP_FLOAT_WRITE_IMM},
    '{PRI_EXT, XO_STATE_WRITE, XM_ALL, XM_NONE, RC_RSVD, OP_STATE_WRITE},
    '{PRI_EXT, XO_SPR_WRITE, XM_ALL, XM_NONE, RC_RSVD, OP_SPR_WRITE},
    // high multiplies, top extended bit reserved
    '{PRI_EXT, XO_MUL_HIGH, XM_LOW9, XM_TOP, RC_REC, OP_MUL_HIGH},
    '{PRI_EXT, XO_MUL_HIGH_U, XM_LOW9, XM_TOP, RC_REC, OP_MUL_HIGH_U},
    '{PRI_MUL_IMM, XO_NONE, XM_NONE, XM_NONE, RC_FREE, OP_MUL_LOW_IMM},
    '{PRI_EXT, XO_MUL_LOW, XM_ALL, XM_NONE, RC_REC, OP_MUL_LOW},
    '{PRI_EXT, XO_MUL_LOW_SUM, XM_ALL, XM_NONE, RC_REC, OP_MUL_LOW_SUM},
    '{PRI_EXT, XO_NEGATE, XM_ALL, XM_NONE, RC_REC, OP_NEGATE},
    '{PRI_EXT, XO_NEGATE_SUM, XM_ALL, XM_NONE, RC_REC, OP_NEGATE_SUM}
  };

  // ==========================================
  // field split
  lmmd_fields_t fld;

  lmmd_field_split u_split (
    .instr_i(fetch_instr_i),
    .fields_o(fld)
  );

  // ==========================================
  // per-entry match
  logic [NUM_PAT-1:0] hit;
  logic [NUM_PAT-1:0] rsvd_set;
  logic [NUM_PAT-1:0] rec;
  logic [5:0] op_chain [NUM_PAT+1];

  assign op_chain[0] = 6'h00;

  for (genvar i = 0; i < NUM_PAT; i++) begin : g_pat
    assign hit[i] = (fld.primary == PAT[i].primary) &&
                    ((fld.xo & PAT[i].xo_mask) == (PAT[i].xo & PAT[i].xo_mask));
    assign rsvd_set[i] = hit[i] && (((fld.xo & PAT[i].res_mask) != XM_NONE) ||
                         ((PAT[i].rc_mode == RC_RSVD) && fld.rc));
    assign rec[i] = hit[i] && (PAT[i].rc_mode == RC_REC) && fld.rc;
    // entries are disjoint, so an or-chain is a clean select
    assign op_chain[i+1] = op_chain[i] | (hit[i] ? PAT[i].op : 6'h00);
  end

  // ==========================================
  // result combine
  wire any_hit = |hit;
  wire any_rsvd = |rsvd_set;
  wire sel_ok = any_hit && !any_rsvd;
  lmmd_dec_t next_dec;

  assign next_dec.op = sel_ok ? lmmd_op_t'(op_chain[NUM_PAT]) : OP_NONE;
  assign next_dec.rec_flags = sel_ok && (|rec);
  assign next_dec.invalid_form = fetch_valid_i && any_rsvd;
  assign next_dec.illegal = fetch_valid_i && !any_hit;

  lmmd_out_stage u_out (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .next_valid_i(fetch_valid_i),
    .next_dec_i(next_dec),
    .valid_o(dec_valid_o),
    .dec_o(dec_o)
  );

  // ==========================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  function automatic logic is_ins(logic [5:0] p, logic [9:0] x);
    return fetch_valid_i && (fld.primary == p) && (fld.xo == x);
  endfunction

  property p_rsvd_final;
    is_ins(PRI_EXT, XO_LD_HALF_X) && fld.rc
      |=> dec_o.invalid_form && (dec_o.op == OP_NONE) && !dec_o.illegal;
  endproperty
  a_rsvd_final: assert property (p_rsvd_final)
    else $error("reserved final bit not flagged");

  property p_dont_care;
    fetch_valid_i && (fld.primary == PRI_LD_WORD)
      |=> (dec_o.op == OP_LD_WORD) && !dec_o.invalid_form;
  endproperty
  a_dont_care: assert property (p_dont_care)
    else $error("operand bits changed a word load");

  property p_half_load;
    is_ins(PRI_EXT, XO_LD_HALF_X) && !fld.rc |=> dec_o.op == OP_LD_HALF_X;
  endproperty
  a_half_load: assert property (p_half_load)
    else $error("halfword load not selected");

  property p_word_upd;
    fetch_valid_i && (fld.primary == PRI_LD_WORD_U) ##1
      dec_valid_o |-> dec_o.op == OP_LD_WORD_U;
  endproperty
  a_word_upd: assert property (p_word_upd)
    else $error("update word load not selected");

  property p_word_ux;
    is_ins(PRI_EXT, XO_LD_WORD_UX) && !fld.rc |=> dec_o.op == OP_LD_WORD_UX;
  endproperty
  a_word_ux: assert property (p_word_ux)
    else $error("update-indexed word load not selected");

  property p_str_imm;
    is_ins(PRI_EXT, XO_LD_STR_IMM) && !fld.rc |=> dec_o.op == OP_LD_STR_IMM;
  endproperty
  a_str_imm: assert property (p_str_imm)
    else $error("string load not selected");

  property p_resv;
    is_ins(PRI_EXT, XO_LD_RESV_X) && !fld.rc |=> dec_o.op == OP_LD_RESV_X;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserve load not selected");

  property p_flags_copy;
    is_ins(PRI_FLAG_OPS, XO_FLAGS_COPY) && !fld.rc
      |=> dec_o.op == OP_FLAGS_COPY;
  endproperty
  a_flags_copy: assert property (p_flags_copy)
    else $error("flags field copy not selected");

  property p_dev_write;
    is_ins(PRI_EXT, XO_DEV_WRITE_X) && !fld.rc |=> dec_o.op == OP_DEV_WRITE_X;
  endproperty
  a_dev_write: assert property (p_dev_write)
    else $error("indexed device write not selected");

  property p_float_rec;
    is_ins(PRI_FLOAT, XO_FLOAT_READ) && fld.rc
      |=> (dec_o.op == OP_FLOAT_READ) && dec_o.rec_flags;
  endproperty
  a_float_rec: assert property (p_float_rec)
    else $error("float status read lost its flags update");

  property p_bit_set;
    is_ins(PRI_FLOAT, XO_FLOAT_BIT_SET) && !fld.rc
      |=> (dec_o.op == OP_FLOAT_BIT_SET) && !dec_o.rec_flags;
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("float bit set decoded wrongly");

  property p_mul_rsvd;
    fetch_valid_i && (fld.primary == PRI_EXT) &&
      ((fld.xo & XM_LOW9) == XO_MUL_HIGH) && fld.xo[XO_HI-XO_LO]
      |=> dec_o.invalid_form && (dec_o.op == OP_NONE);
  endproperty
  a_mul_rsvd: assert property (p_mul_rsvd)
    else $error("high multiply reserved bit not flagged");

  property p_neg_rec;
    is_ins(PRI_EXT, XO_NEGATE_SUM) && fld.rc
      |=> (dec_o.op == OP_NEGATE_SUM) && dec_o.rec_flags;
  endproperty
  a_neg_rec: assert property (p_neg_rec)
    else $error("overflow negate decoded wrongly");

  property p_rev_load;
    is_ins(PRI_EXT, XO_LD_REV_X) && !fld.rc |=> dec_o.op == OP_LD_REV_X;
  endproperty
  a_rev_load: assert property (p_rev_load)
    else $error("byte-reverse load not selected");

  property p_fxe_flags;
    is_ins(PRI_EXT, XO_FLAGS_FROM_FXE) && !fld.rc |=> dec_o.op == OP_FLAGS_FROM_FXE;
  endproperty
  a_fxe_flags: assert property (p_fxe_flags)
    else $error("exception summary move not selected");

  property p_float_flags;
    is_ins(PRI_FLOAT, XO_FLAGS_FROM_FLOAT) && !fld.rc
      |=> dec_o.op == OP_FLAGS_FROM_FLOAT;
  endproperty
  a_float_flags: assert property (p_float_flags)
    else $error("float field move not selected");

  property p_dev_read;
    is_ins(PRI_EXT, XO_DEV_READ) && !fld.rc |=> dec_o.op == OP_DEV_READ;
  endproperty
  a_dev_read: assert property (p_dev_read)
    else $error("device space read not selected");

  property p_spr_write;
    is_ins(PRI_EXT, XO_SPR_WRITE) && !fld.rc |=> dec_o.op == OP_SPR_WRITE;
  endproperty
  a_spr_write: assert property (p_spr_write)
    else $error("special register write not selected");

  property p_float_write;
    is_ins(PRI_FLOAT, XO_FLOAT_WRITE) && fld.rc
      |=> (dec_o.op == OP_FLOAT_WRITE) && dec_o.rec_flags;
  endproperty
  a_float_write: assert property (p_float_write)
    else $error("masked float status write decoded wrongly");

  property p_mul_sum;
    is_ins(PRI_EXT, XO_MUL_LOW_SUM) |=> (dec_o.op == OP_MUL_LOW_SUM) && !dec_o.invalid_form;
  endproperty
  a_mul_sum: assert property (p_mul_sum)
    else $error("overflow-recording multiply decoded wrongly");

  property p_msb_first;
    fetch_valid_i && (fetch_instr_i[PRI_HI:PRI_LO] == PRI_MUL_IMM)
      |=> dec_o.op == OP_MUL_LOW_IMM;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("primary opcode taken from wrong bits");

  property p_illegal;
    is_ins(PRI_FLOAT, XM_ALL)
      |=> dec_o.illegal && (dec_o.op == OP_NONE) && !dec_o.rec_flags;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("unmatched encoding not illegal");

  property p_flags_quiet;
    !fetch_valid_i |=> !dec_valid_o && !dec_o.illegal && !dec_o.invalid_form;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet)
    else $error("indication raised without a fetch");

  c_load: cover property (is_ins(PRI_EXT, XO_LD_REV_X) ##1 dec_valid_o);
  c_rec: cover property (is_ins(PRI_EXT, XO_MUL_LOW) && fld.rc);
  c_invalid: cover property (dec_o.invalid_form);
  c_illegal: cover property (dec_o.illegal);

endmodule

/* File: testbench/lmmd_fetch_model.sv */
// behavioural fetch unit presenting one instruction word per cycle
`timescale 1ns/1ps
module lmmd_fetch_model (
  input wire logic ref_clk_i,
  output logic fetch_valid_o,
  output logic [lmmd_pkg::LMMD_INSTR_W-1:0] fetch_instr_o
);
  import lmmd_pkg::*;

  initial begin
    fetch_valid_o = 1'b0;
    fetch_instr_o = 32'h0000_0000;
  end

  // ==========================================
  // word delivery, launched on the falling edge
  task automatic send(input logic [LMMD_INSTR_W-1:0] word, input logic valid);
    @(negedge ref_clk_i);
    fetch_valid_o = valid;
    fetch_instr_o = word;
  endtask

  // a stale word is not held: its inverse keeps an old match from passing by luck
  task automatic idle();
    @(negedge ref_clk_i);
    fetch_valid_o = 1'b0;
    fetch_instr_o = ~fetch_instr_o;
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the load/move/multiply decoder
`timescale 1ns/1ps
module testbench;
  import lmmd_pkg::*;
  logic ref_clk_i;
  logic reset_n_i;
  logic fetch_valid_i;
  logic [LMMD_INSTR_W-1:0] fetch_instr_i;
  logic dec_valid_o;
  lmmd_dec_t dec_o;
  int failures = 0;
  int compares = 0;
  logic [14:0] opnd = 15'h0000;

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  lmmd_fetch_model i_lmmd_fetch_model (
    .ref_clk_i(ref_clk_i),
    .fetch_valid_o(fetch_valid_i),
    .fetch_instr_o(fetch_instr_i)
  );

  lmmd_decoder #(.NUM_PAT(LMMD_NUM_PAT)) i_lmmd_decoder (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .fetch_valid_i(fetch_valid_i),
    .fetch_instr_i(fetch_instr_i),
    .dec_valid_o(dec_valid_o),
    .dec_o(dec_o)
  );

  // ==========================================
  // comparison and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // word building and one-cycle decode check
  function automatic logic [31:0] mk(input logic [5:0] pri, input logic [9:0] xo,
                                     input logic rc);
    return {pri, opnd, xo, rc};
  endfunction

  // flags are {rec_flags, invalid_form, illegal}
  task automatic expect_dec(input logic [31:0] word, input lmmd_op_t op, input logic [2:0] flags);
    i_lmmd_fetch_model.send(word, 1'b1);
    @(posedge ref_clk_i);
    #1;
    check("dec_valid_o", {31'h0000_0000, dec_valid_o}, 32'h0000_0001);
    check("dec_o", {23'h00_0000, dec_o}, {23'h00_0000, op, flags});
  endtask

  // final bit reserved: one must give an invalid form
  task automatic rsvd(input logic [5:0] pri, input logic [9:0] xo, input lmmd_op_t op);
    expect_dec(mk(pri, xo, 1'b0), op, 3'b000);
    expect_dec(mk(pri, xo, 1'b1), OP_NONE, 3'b010);
  endtask

  // final bit one requests a flags update on the same operation
  task automatic recd(input logic [5:0] pri, input logic [9:0] xo, input lmmd_op_t op);
    expect_dec(mk(pri, xo, 1'b0), op, 3'b000);
    expect_dec(mk(pri, xo, 1'b1), op, 3'b100);
  endtask

  // ==========================================
  // scenarios
  task automatic t_loads();
    opnd = 15'h7fff;
    rsvd(6'h1f, 10'h117, OP_LD_HALF_X);
    rsvd(6'h1f, 10'h255, OP_LD_STR_IMM);
    rsvd(6'h1f, 10'h215, OP_LD_STR_X);
    rsvd(6'h1f, 10'h014, OP_LD_RESV_X);
    rsvd(6'h1f, 10'h216, OP_LD_REV_X);
    rsvd(6'h1f, 10'h037, OP_LD_WORD_UX);
    rsvd(6'h1f, 10'h017, OP_LD_WORD_X);
  endtask

  // d-form words carry operand data in the low bits, so the final bit is ignored
  task automatic t_dforms();
    opnd = 15'h5a5a;
    expect_dec(mk(6'h20, 10'h3ff, 1'b1), OP_LD_WORD, 3'b000);
    expect_dec(mk(6'h21, 10'h155, 1'b1), OP_LD_WORD_U, 3'b000);
    expect_dec(mk(6'h07, 10'h2aa, 1'b1), OP_MUL_LOW_IMM, 3'b000);
  endtask

  task automatic t_moves();
    opnd = 15'h2aaa;
    rsvd(6'h13, 10'h000, OP_FLAGS_COPY);
    rsvd(6'h1f, 10'h200, OP_FLAGS_FROM_FXE);
    rsvd(6'h3f, 10'h040, OP_FLAGS_FROM_FLOAT);
    rsvd(6'h1f, 10'h013, OP_FLAGS_TO_GPR);
    rsvd(6'h1f, 10'h143, OP_DEV_READ);
    rsvd(6'h1f, 10'h103, OP_DEV_READ_X);
    rsvd(6'h1f, 10'h1c3, OP_DEV_WRITE);
    rsvd(6'h1f, 10'h183, OP_DEV_WRITE_X);
    rsvd(6'h1f, 10'h053, OP_STATE_READ);
    rsvd(6'h1f, 10'h092, OP_STATE_WRITE);
    rsvd(6'h1f, 10'h153, OP_SPR_READ);
    rsvd(6'h1f, 10'h1d3, OP_SPR_WRITE);
    rsvd(6'h1f, 10'h090, OP_FLAGS_WRITE);
  endtask

  task automatic t_float();
    opnd = 15'h1234;
    recd(6'h3f, 10'h247, OP_FLOAT_READ);
    recd(6'h3f, 10'h046, OP_FLOAT_BIT_CLR);
    recd(6'h3f, 10'h026, OP_FLOAT_BIT_SET);
    recd(6'h3f, 10'h2c7, OP_FLOAT_WRITE);
    recd(6'h3f, 10'h086, OP_FLOAT_WRITE_IMM);
  endtask

  task automatic t_mul_neg();
    opnd = 15'h4321;
    recd(6'h1f, 10'h04b, OP_MUL_HIGH);
    recd(6'h1f, 10'h00b, OP_MUL_HIGH_U);
    expect_dec(mk(6'h1f, 10'h24b, 1'b0), OP_NONE, 3'b010);
    expect_dec(mk(6'h1f, 10'h20b, 1'b1), OP_NONE, 3'b010);
    recd(6'h1f, 10'h0eb, OP_MUL_LOW);
    recd(6'h1f, 10'h2eb, OP_MUL_LOW_SUM);
    recd(6'h1f, 10'h068, OP_NEGATE);
    recd(6'h1f, 10'h268, OP_NEGATE_SUM);
  endtask

  task automatic t_dont_care();
    logic [14:0] pats [4];
    pats = '{15'h0000, 15'h7fff, 15'h0f0f, 15'h70f0};
    foreach (pats[k]) begin
      opnd = pats[k];
      expect_dec(mk(6'h1f, 10'h153, 1'b0), OP_SPR_READ, 3'b000);
    end
  endtask

  task automatic t_illegal();
    opnd = 15'h0000;
    expect_dec(mk(6'h3f, 10'h3ff, 1'b0), OP_NONE, 3'b001);
    expect_dec(mk(6'h1f, 10'h356, 1'b0), OP_NONE, 3'b001);
    expect_dec(mk(6'h2e, 10'h000, 1'b0), OP_NONE, 3'b001);
    expect_dec(mk(6'h1e, 10'h017, 1'b0), OP_NONE, 3'b001);
    expect_dec(mk(6'h01, 10'h000, 1'b0), OP_NONE, 3'b001);
    expect_dec(mk(6'h1f, 10'h3a0, 1'b0), OP_NONE, 3'b001);
  endtask

  // without a valid fetch no fault flag may reach the exception logic
  task automatic t_no_fetch();
    i_lmmd_fetch_model.send(mk(6'h3f, 10'h3ff, 1'b1), 1'b0);
    @(posedge ref_clk_i);
    #1;
    check("dec_valid_o", {31'h0000_0000, dec_valid_o}, 32'h0000_0000);
    check("fault flags", {30'h0000_0000, dec_o.invalid_form, dec_o.illegal}, 32'h0);
    i_lmmd_fetch_model.idle();
  endtask

  task automatic t_mid_reset();
    expect_dec(mk(6'h1f, 10'h017, 1'b0), OP_LD_WORD_X, 3'b000);
    @(negedge ref_clk_i);
    reset_n_i = 1'b0;
    #1;
    check("dec_valid_o", {31'h0000_0000, dec_valid_o}, 32'h0000_0000);
    check("dec_o", {23'h00_0000, dec_o}, {23'h00_0000, DEC_IDLE});
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    expect_dec(mk(6'h1f, 10'h117, 1'b1), OP_NONE, 3'b010);
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    reset_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_loads();
    t_dforms();
    t_moves();
    t_float();
    t_mul_neg();
    t_dont_care();
    t_illegal();
    t_no_fetch();
    t_mid_reset();
    close_out();
  end

  // about 80 words are decoded; this leaves a wide margin
  initial begin
    #20000;
    failures++;
    close_out();
  end
endmodule
